// ---- rtl/vrcc_regs.sv ----
// Channel 0 resource capability and control registers of the bridge.
// Assumes single-cycle configuration requests on sys_clk from the
// configuration decoder, and that other blocks answer other offsets.
`timescale 1ns/100ps
`default_nettype none
`include "vrcc_defines.svh"

// Functional notes
// RULE1 - Capability register at 0x160 is read-only, reset value 0x00000001.
// RULE2 - Capability bits 31:24 read 0x00: no port arbitration table.
// RULE3 - Maximum time-slot field, bits 22:16, reads zero.
// RULE4 - Snoop-rejection bit 15 reads 0.
// RULE5 - Bit 14 reads 0: channel not limited to switching traffic.
// RULE6 - Reserved capability bits 23 and 13:8 read zero.
// RULE7 - Ability bits: fixed RR, WRR 32/64/128, time WRR 128, WRR 256.
// RULE8 - Ability field reads 0x01: only fixed round-robin.
// RULE9 - Control register at 0x164 is mixed access, reset 0x800000FF.
// RULE10 - Channel enable bit 31 is hardwired to 1.
// RULE11 - Channel identifier bits 26:24 hardwired to 000b.
// RULE12 - Arbitration select bits 19:17 read-only, return 000b.
// RULE13 - Table-load bit 16 is read-only and returns 0.
// RULE14 - Reserved control bits 30:27, 23:20, 15:8 read zero.
// RULE15 - Control bits 7:0 are a writable class-to-channel map.
// RULE16 - Map bit 0 is read-only and always 1.
// RULE17 - Map resets to 0xFF, all classes on channel 0.
// RULE18 - Writes change only map bits 7:1; all else stays.
module vrcc_regs
  import vrcc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Configuration access
  input  wire vrcc_req_t  cfgReq,
  output vrcc_rsp_t       cfgRsp,
  // Channel settings toward the arbiters
  output logic [7:0]      trafficClassMapping,
  output logic            channelEnable,
  output logic [2:0]      channelIdentifier,
  output logic [2:0]      arbitrationSchemeChoice,
  output logic [7:0]      arbitrationAbilityField,
  // Traffic class routing query
  input  wire logic       tcQueryValid,
  input  wire logic [2:0] tcQueryClass,
  output logic            tcQueryDone,
  output logic            tcQueryHit
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------

  // Decodes an extended offset into one of the two registers.
  function automatic vrcc_sel_t decodeSel(
    input logic [`VRCC_ADDR_W-1:0] addr
  );
    vrcc_sel_t sel;
    sel = VRCC_SEL_NONE;
    if (addr == `VRCC_CAP_OFFSET) begin
      sel = VRCC_SEL_CAP;
    end else if (addr == `VRCC_CTL_OFFSET) begin
      sel = VRCC_SEL_CTL;
    end
    return sel;
  endfunction : decodeSel

  // Builds the constant capability word.
  function automatic vrcc_cap_t buildCap();
    vrcc_cap_t cap;
    cap                         = '0;            // see RULE6
    cap.tableLocation           = `VRCC_TBL_LOC_VAL;  // see RULE2
    cap.maxTimeSlots            = `VRCC_SLOTS_VAL;    // see RULE3
    cap.snoopReject             = `VRCC_SNOOP_VAL;    // see RULE4
    cap.advancedSwitchingOnly   = `VRCC_ASONLY_VAL;   // see RULE5
    cap.arbitrationAbilityField = `VRCC_ABILITY_VAL;  // see RULE8
    return cap;
  endfunction : buildCap

  // Builds the control word around the stored map.
  function automatic vrcc_ctl_t buildCtl(input logic [7:0] map);
    vrcc_ctl_t ctl;
    ctl                         = '0;            // see RULE14
    ctl.channelEnable           = `VRCC_CHAN_EN_VAL;  // see RULE10
    ctl.channelIdentifier       = `VRCC_CHAN_ID_VAL;  // see RULE11
    ctl.arbitrationSchemeChoice = `VRCC_ARB_SEL_VAL;  // see RULE12
    ctl.tableLoad               = `VRCC_TBL_LOAD_VAL; // see RULE13
    ctl.trafficClassMapping     = map;                // see RULE15
    return ctl;
  endfunction : buildCtl

  // Reports whether a given ability bit is advertised.
  function automatic logic abilityHas(
    input logic [7:0] ability,
    input int unsigned pos
  );
    return ability[pos[2:0]];
  endfunction : abilityHas

  // --------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------

  vrcc_sel_t   accSel;
  logic        accHit;
  logic        mapWr;
  logic [7:0]  mapQ;
  vrcc_cap_t   capWord;
  vrcc_ctl_t   ctlWord;
  logic [31:0] rdWord;

  assign accSel  = decodeSel(cfgReq.addr);
  assign accHit  = (accSel != VRCC_SEL_NONE);
  assign capWord = buildCap();                    // see RULE1
  assign ctlWord = buildCtl(mapQ);                // see RULE9

  // Only byte lane 0 of the control register carries writable bits, so
  // the capability register and all upper lanes simply drop writes.
  assign mapWr = cfgReq.wr && (accSel == VRCC_SEL_CTL)
                 && cfgReq.byteEn[0];             // see RULE18

  // --------------------------------------------------------------------
  // Traffic class map storage
  // --------------------------------------------------------------------

  vrcc_map_reg vrcc_map_reg_i (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .mapWr     (mapWr),
    .mapWrData (cfgReq.wrData[7:0]),
    .mapQ      (mapQ)
  );

  // --------------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------------

  always_comb begin
    rdWord = '0;
    unique case (accSel)
      VRCC_SEL_CAP: begin
        rdWord = capWord;                         // see RULE1
      end
      VRCC_SEL_CTL: begin
        rdWord = ctlWord;                         // see RULE9
      end
      VRCC_SEL_NONE: begin
        rdWord = '0;
      end
      default: begin
        rdWord = '0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Configuration answer
  // --------------------------------------------------------------------

  logic        rdValid_ff;
  logic        wrDone_ff;
  logic        hit_ff;
  logic [31:0] rdData_ff;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdValid_ff <= 1'b0;
      wrDone_ff  <= 1'b0;
    end else begin
      rdValid_ff <= cfgReq.rd;
      wrDone_ff  <= cfgReq.wr && !cfgReq.rd;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_ff <= 1'b0;
    end else if (cfgReq.rd || cfgReq.wr) begin
      hit_ff <= accHit;
    end else begin
      hit_ff <= 1'b0;
    end
  end

  // Read data are held between reads and forced to zero on a miss.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_ff <= '0;
    end else if (cfgReq.rd) begin
      rdData_ff <= rdWord;                        // see RULE6
    end
  end

  assign cfgRsp.rdValid = rdValid_ff;
  assign cfgRsp.wrDone  = wrDone_ff;
  assign cfgRsp.hit     = hit_ff;
  assign cfgRsp.rdData  = rdData_ff;

  // --------------------------------------------------------------------
  // Channel settings
  // --------------------------------------------------------------------

  logic [7:0] tcMap_ff;
  logic       chanEn_ff;
  logic [2:0] chanId_ff;
  logic [2:0] arbSel_ff;
  logic [7:0] ability_ff;

  // The arbiters see the map one cycle after it changes.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tcMap_ff <= `VRCC_MAP_RESET;                // see RULE17
    end else begin
      tcMap_ff <= ctlWord.trafficClassMapping;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chanEn_ff  <= `VRCC_CHAN_EN_VAL;
      chanId_ff  <= `VRCC_CHAN_ID_VAL;
      arbSel_ff  <= `VRCC_ARB_SEL_VAL;
      ability_ff <= `VRCC_ABILITY_VAL;
    end else begin
      chanEn_ff  <= ctlWord.channelEnable;        // see RULE10
      chanId_ff  <= ctlWord.channelIdentifier;    // see RULE11
      arbSel_ff  <= ctlWord.arbitrationSchemeChoice; // see RULE12
      ability_ff <= capWord.arbitrationAbilityField; // see RULE7
    end
  end

  assign trafficClassMapping     = tcMap_ff;
  assign channelEnable           = chanEn_ff;
  assign channelIdentifier       = chanId_ff;
  assign arbitrationSchemeChoice = arbSel_ff;
  assign arbitrationAbilityField = ability_ff;

  // --------------------------------------------------------------------
  // Advertised arbitration schemes
  // --------------------------------------------------------------------

  // Only the fixed round-robin scheme is advertised, so the arbiter is
  // never asked to run a weighted or time-based schedule.
  logic fixedRrOk;
  logic weightedOk;

  assign fixedRrOk  = abilityHas(ability_ff, `VRCC_ABL_FIXED_RR); // see RULE7
  assign weightedOk = abilityHas(ability_ff, `VRCC_ABL_WRR32)
                      || abilityHas(ability_ff, `VRCC_ABL_WRR64)
                      || abilityHas(ability_ff, `VRCC_ABL_WRR128)
                      || abilityHas(ability_ff, `VRCC_ABL_TWRR128)
                      || abilityHas(ability_ff, `VRCC_ABL_WRR256);

  // --------------------------------------------------------------------
  // Traffic class routing query
  // --------------------------------------------------------------------

  logic queryDone_ff;
  logic queryHit_ff;

  // A class routes here only while mapped, the channel is enabled and any scheme is advertised.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      queryDone_ff <= 1'b0;
      queryHit_ff  <= 1'b0;
    end else begin
      queryDone_ff <= tcQueryValid;
      if (tcQueryValid) begin
        queryHit_ff <= tcMap_ff[tcQueryClass] && chanEn_ff
                       && (fixedRrOk || weightedOk);  // see RULE15
      end
    end
  end

  assign tcQueryDone = queryDone_ff;
  assign tcQueryHit  = queryHit_ff;

endmodule : vrcc_regs

`default_nettype wire

// ---- inc/vrcc_defines.svh ----
// Constants of the channel 0 resource capability and control registers.
// Assumes inclusion by bare name from the package and the design files.
`ifndef VRCC_DEFINES_SVH
`define VRCC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets in extended configuration space
// ----------------------------------------------------------------------
`define VRCC_ADDR_W        12
`define VRCC_CAP_OFFSET    12'h160
`define VRCC_CTL_OFFSET    12'h164

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VRCC_CAP_RESET     32'h0000_0001
`define VRCC_CTL_RESET     32'h8000_00FF
`define VRCC_MAP_RESET     8'hFF

// ----------------------------------------------------------------------
// Capability fields
// ----------------------------------------------------------------------
`define VRCC_TBL_LOC_VAL   8'h00
`define VRCC_SLOTS_VAL     7'h00
`define VRCC_SNOOP_VAL     1'h0
`define VRCC_ASONLY_VAL    1'h0
`define VRCC_ABILITY_VAL   8'h01
`define VRCC_ABL_FIXED_RR  0
`define VRCC_ABL_WRR32     1
`define VRCC_ABL_WRR64     2
`define VRCC_ABL_WRR128    3
`define VRCC_ABL_TWRR128   4
`define VRCC_ABL_WRR256    5

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define VRCC_CHAN_EN_VAL   1'h1
`define VRCC_CHAN_ID_VAL   3'h0
`define VRCC_ARB_SEL_VAL   3'h0
`define VRCC_TBL_LOAD_VAL  1'h0
`define VRCC_MAP_FIXED     1'h1
`define VRCC_MAP_LANE      0

`endif

// ---- inc/vrcc_pkg.sv ----
// Types shared by the channel 0 register bank and its helper module.
// Assumes the defines header is on the include path.
`include "vrcc_defines.svh"

package vrcc_pkg;

  // Configuration access request, one cycle per access.
  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [`VRCC_ADDR_W-1:0]  addr;
    logic [3:0]               byteEn;
    logic [31:0]              wrData;
  } vrcc_req_t;

  // Configuration access answer.
  typedef struct packed {
    logic        rdValid;
    logic        wrDone;
    logic        hit;
    logic [31:0] rdData;
  } vrcc_rsp_t;

  // Capability register layout.
  typedef struct packed {
    logic [7:0] tableLocation;
    logic       rsvd23;
    logic [6:0] maxTimeSlots;
    logic       snoopReject;
    logic       advancedSwitchingOnly;
    logic [5:0] rsvd13to8;
    logic [7:0] arbitrationAbilityField;
  } vrcc_cap_t;

  // Control register layout.
  typedef struct packed {
    logic       channelEnable;
    logic [3:0] rsvd30to27;
    logic [2:0] channelIdentifier;
    logic [3:0] rsvd23to20;
    logic [2:0] arbitrationSchemeChoice;
    logic       tableLoad;
    logic [7:0] rsvd15to8;
    logic [7:0] trafficClassMapping;
  } vrcc_ctl_t;

  typedef enum logic [1:0] {
    VRCC_SEL_NONE = 2'b00,
    VRCC_SEL_CAP  = 2'b01,
    VRCC_SEL_CTL  = 2'b10
  } vrcc_sel_t;

endpackage : vrcc_pkg

// ---- rtl/vrcc_map_reg.sv ----
// Writable traffic class map of channel 0.
// Assumes a write strobe already qualified by address and byte lane 0.
`timescale 1ns/100ps
`default_nettype none
`include "vrcc_defines.svh"

module vrcc_map_reg
  import vrcc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Write side
  input  wire logic       mapWr,
  input  wire logic [7:0] mapWrData,
  // Stored map
  output logic [7:0]      mapQ
);

  logic [7:0] map_ff;
  logic [7:0] nxt_map;

  // Class 0 is forced mapped; the other classes take the written bits.
  always_comb begin
    nxt_map = map_ff;
    if (mapWr) begin
      nxt_map = mapWrData;                       // see RULE18
    end
    nxt_map[`VRCC_MAP_LANE] = `VRCC_MAP_FIXED;   // see RULE16
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      map_ff <= `VRCC_MAP_RESET;                 // see RULE17
    end else begin
      map_ff <= nxt_map;                         // see RULE15
    end
  end

  assign mapQ = map_ff;

endmodule : vrcc_map_reg

`default_nettype wire

// ---- sim/vrcc_regs_props.sv ----
// Concurrent checks on the ports of the channel 0 register bank.
// Assumes vrcc_pkg is compiled first; bound to every vrcc_regs below.
`timescale 1ns/100ps
`default_nettype none

module vrcc_regs_props
  import vrcc_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Configuration access
  input wire vrcc_req_t  cfgReq,
  input wire vrcc_rsp_t  cfgRsp,
  // Channel settings and query
  input wire logic [7:0] trafficClassMapping,
  input wire logic       channelEnable,
  input wire logic [2:0] channelIdentifier,
  input wire logic [2:0] arbitrationSchemeChoice,
  input wire logic [7:0] arbitrationAbilityField,
  input wire logic       tcQueryValid,
  input wire logic [2:0] tcQueryClass,
  input wire logic       tcQueryDone,
  input wire logic       tcQueryHit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_rd_cap;
    cfgReq.rd && cfgReq.addr == 12'h160;
  endsequence
  sequence s_rd_ctl;
    cfgReq.rd && cfgReq.addr == 12'h164;
  endsequence
  sequence s_map_wr;
    cfgReq.wr && cfgReq.addr == 12'h164 && cfgReq.byteEn[0];
  endsequence

  a_cap_value: assert property (s_rd_cap |=>
    cfgRsp.rdData == 32'h0000_0001 && cfgRsp.hit)
    else $error("capability read wrong");
  a_ctl_fixed: assert property (s_rd_ctl |=>
    cfgRsp.rdData[31:8] == 24'h80_0000 && cfgRsp.rdData[0])
    else $error("control fixed bits wrong");
  a_map_update: assert property (s_map_wr |-> ##2
    trafficClassMapping == {$past(cfgReq.wrData[7:1], 2), 1'b1})
    else $error("map write not applied");
  a_unmapped_read: assert property (cfgReq.rd
    && cfgReq.addr != 12'h160 && cfgReq.addr != 12'h164
    |=> cfgRsp.rdValid && !cfgRsp.hit && cfgRsp.rdData == 32'h0000_0000)
    else $error("unmapped read answered wrongly");
  a_write_done: assert property (cfgReq.wr |=> cfgRsp.wrDone == !$past(cfgReq.rd))
    else $error("write completion wrong");
  a_idle_quiet: assert property (!cfgReq.rd && !cfgReq.wr |=>
    !cfgRsp.rdValid && !cfgRsp.wrDone)
    else $error("answer without request");
  a_fixed_outs: assert property (channelEnable && channelIdentifier == 3'h0
    && arbitrationSchemeChoice == 3'h0 && arbitrationAbilityField == 8'h01)
    else $error("hardwired output wrong");
  a_map_bit0: assert property (trafficClassMapping[0]
    && $stable(trafficClassMapping[0]))
    else $error("class 0 unmapped");
  a_query_hit: assert property (tcQueryValid |=> tcQueryDone
    && tcQueryHit == $past(trafficClassMapping[tcQueryClass]))
    else $error("query answer wrong");
endmodule : vrcc_regs_props

bind vrcc_regs vrcc_regs_props vrcc_regs_props_i (.sys_clk, .sys_rst, .cfgReq, .cfgRsp,
  .trafficClassMapping, .channelEnable, .channelIdentifier, .arbitrationSchemeChoice,
  .arbitrationAbilityField, .tcQueryValid, .tcQueryClass, .tcQueryDone, .tcQueryHit);

`default_nettype wire

// ---- sim/vrcc_regs_tb_top.sv ----
// Self-checking bench of the channel 0 register bank.
// Assumes vrcc_pkg and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module vrcc_regs_tb_top
  import vrcc_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] d;
    logic [31:0] exp;
    logic        hit;
  } vrcc_row_t;

  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  vrcc_req_t  cfgReq = '0;
  vrcc_rsp_t  cfgRsp;
  logic [7:0] trafficClassMapping;
  logic       channelEnable;
  logic [2:0] channelIdentifier;
  logic [2:0] arbitrationSchemeChoice;
  logic [7:0] arbitrationAbilityField;
  logic       tcQueryValid = 1'b0;
  logic [2:0] tcQueryClass = 3'h0;
  logic       tcQueryDone;
  logic       tcQueryHit;
  int         fails = 0;
  int         nCompared = 0;
  int         cycles = 0;
  vrcc_row_t  rows [12] = '{
    '{1'b0, 1'b1, 12'h160, 4'h0, 32'h0000_0000, 32'h0000_0001, 1'b1},
    '{1'b0, 1'b1, 12'h164, 4'h0, 32'h0000_0000, 32'h8000_00FF, 1'b1},
    '{1'b1, 1'b0, 12'h164, 4'hF, 32'hFFFF_FF00, 32'h0000_0000, 1'b1},
    '{1'b0, 1'b1, 12'h164, 4'h0, 32'h0000_0000, 32'h8000_0001, 1'b1},
    '{1'b1, 1'b0, 12'h164, 4'hE, 32'h0000_00AA, 32'h0000_0000, 1'b1},
    '{1'b0, 1'b1, 12'h164, 4'h0, 32'h0000_0000, 32'h8000_0001, 1'b1},
    '{1'b1, 1'b0, 12'h160, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
    '{1'b0, 1'b1, 12'h160, 4'h0, 32'h0000_0000, 32'h0000_0001, 1'b1},
    '{1'b1, 1'b0, 12'h164, 4'h1, 32'h7FFF_FF5A, 32'h0000_0000, 1'b1},
    '{1'b0, 1'b1, 12'h164, 4'h0, 32'h0000_0000, 32'h8000_005B, 1'b1},
    '{1'b0, 1'b1, 12'h100, 4'h0, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, 1'b1, 12'h168, 4'h0, 32'h0000_0000, 32'h0000_0000, 1'b0}
  };

  vrcc_regs vrcc_regs_i (.sys_clk, .sys_rst, .cfgReq, .cfgRsp, .trafficClassMapping,
    .channelEnable, .channelIdentifier, .arbitrationSchemeChoice, .arbitrationAbilityField,
    .tcQueryValid, .tcQueryClass, .tcQueryDone, .tcQueryHit);

  always #20 sys_clk = ~sys_clk;

  // -------------------------------------------------------------------
  // Access and compare tasks
  // -------------------------------------------------------------------
  task automatic acc(input logic w, input logic r, input logic [11:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(negedge sys_clk);
    cfgReq = '{w, r, a, b, d};
    @(negedge sys_clk);
    cfgReq = '0;
  endtask : acc

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp, input string m);
    chk32({31'h0, got}, {31'h0, exp}, m);
  endtask : chk1

  task automatic finishTest;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finishTest

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      finishTest();
    end
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk32({24'h0, trafficClassMapping}, 32'h0000_00FF, "map reset");
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].rd, rows[i].addr, rows[i].be, rows[i].d);
      chk1(cfgRsp.hit, rows[i].hit, "hit");
      chk1(cfgRsp.rdValid, rows[i].rd, "rdValid");
      chk1(cfgRsp.wrDone, rows[i].wr, "wrDone");
      if (rows[i].rd) chk32(cfgRsp.rdData, rows[i].exp, "rdData");
    end
    chk32({channelEnable, channelIdentifier, arbitrationSchemeChoice, arbitrationAbilityField,
           17'h0}, 32'h8002_0000, "fixed outputs");
    // Each class query compares against the map 0x5B written above.
    for (int c = 0; c < 8; c++) begin
      @(negedge sys_clk);
      tcQueryValid = 1'b1;
      tcQueryClass = c[2:0];
      @(negedge sys_clk);
      tcQueryValid = 1'b0;
      chk1(tcQueryDone, 1'b1, "query done");
      chk1(tcQueryHit, c inside {0, 1, 3, 4, 6}, "query hit");
    end
    // A write followed at once by a read must see the new map.
    @(negedge sys_clk);
    cfgReq = '{1'b1, 1'b0, 12'h164, 4'h1, 32'h0000_0024};
    @(negedge sys_clk);
    cfgReq = '{1'b0, 1'b1, 12'h164, 4'h0, 32'h0000_0000};
    chk1(cfgRsp.wrDone, 1'b1, "b2b wrDone");
    @(negedge sys_clk);
    cfgReq = '0;
    chk32(cfgRsp.rdData, 32'h8000_0025, "b2b rdData");
    chk32({24'h0, trafficClassMapping}, 32'h0000_0025, "map out");
    // Read and write together: read answered, write applied silently.
    acc(1'b1, 1'b1, 12'h164, 4'h1, 32'h0000_00F0);
    chk1(cfgRsp.wrDone, 1'b0, "rw wrDone");
    chk1(cfgRsp.rdValid, 1'b1, "rw rdValid");
    acc(1'b0, 1'b1, 12'h164, 4'h0, 32'h0000_0000);
    chk32(cfgRsp.rdData, 32'h8000_00F1, "rw rdData");
    // Reset in mid-run restores the map.
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk32({24'h0, trafficClassMapping}, 32'h0000_00FF, "map rst");
    sys_rst = 1'b0;
    acc(1'b0, 1'b1, 12'h164, 4'h0, 32'h0000_0000);
    chk32(cfgRsp.rdData, 32'h8000_00FF, "ctl rst");
    finishTest();
  end
endmodule : vrcc_regs_tb_top

`default_nettype wire
